// ### logic/sram_ctl_defines.svh
/*
 Timing and geometry constants for the asynchronous 128K x 8 memory
 controller. Assumes a 20 MHz controller clock (50 ns period).
*/
`ifndef SRAM_CTL_DEFINES_SVH
`define SRAM_CTL_DEFINES_SVH
`define CLK_PERIOD_NS 50
`define ADDR_W 17
`define DATA_W 8
`define WORD_COUNT 131072
// Device timing figures in ns, fastest grade
`define SELECT_TO_DATA_DELAY_NS 12
`define DATA_HOLD_AFTER_ADDRESS_CHANGE_NS 4
`define OUTPUT_ENABLE_TO_DATA_DELAY_NS 6
`define SELECT_BEFORE_WRITE_END_NS 10
`define ADDRESS_BEFORE_WRITE_END_NS 9
`define ADDRESS_AFTER_WRITE_END_NS 0
`define DESELECT_TO_LOW_POWER_NS 12
`define WRITE_STROBE_TO_BUS_RELEASE_NS 6
`define DESELECT_BEFORE_RETENTION_NS 0
`define READ_CYCLE_NS 12
// Least times round up, never below one cycle
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS < 1 ? \
    1 : ((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC `NS_TO_CYC(`SELECT_TO_DATA_DELAY_NS)
`define WRITE_PULSE_CYC `NS_TO_CYC(`SELECT_BEFORE_WRITE_END_NS)
`define BUS_RELEASE_CYC `NS_TO_CYC(`WRITE_STROBE_TO_BUS_RELEASE_NS)
`define RECOVERY_CYC `NS_TO_CYC(`READ_CYCLE_NS)
`define CNT_W 4
`endif

// ### logic/sram_ctl_pkg.sv
/*
 Types shared by the memory controller files.
 Assumes sram_ctl_defines.svh is on the include path.
*/
`include "sram_ctl_defines.svh"
`default_nettype none
package sram_ctl_pkg;
    // Pins towards the memory, all strobes active low
    typedef struct packed {
        logic [`ADDR_W-1:0] word_address;
        logic chip_sel_n;
        logic out_en_n;
        logic write_n;
    } mem_ctrl_t;
    // User request
    typedef struct packed {
        logic write;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } mem_req_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RD_WAIT = 6'h02,
        ST_WR_SETUP = 6'h04,
        ST_WR_PULSE = 6'h08,
        ST_WR_END = 6'h10,
        ST_RETAIN = 6'h20
    } ctl_state_t;
endpackage
`default_nettype wire

// ### logic/sram_dly_cnt.sv
/*
 Down counter that times strobe phases in whole clock cycles.
 Assumes a synchronous load from the controller state machine.
*/
`include "sram_ctl_defines.svh"
`default_nettype none
module sram_dly_cnt (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [`CNT_W-1:0] value_i,
    output logic done_o
);
    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] cnt_d;

    // Load wins, otherwise count down to zero and hold
    always_comb
    begin
        cnt_d = cnt_q;
        if (load_i)
            cnt_d = value_i;
        else if (cnt_q != 4'h0)
            cnt_d = cnt_q - 4'h1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_d;
    end

    // Done reads the count only: a load that is decided on done must not
    // feed back into done, or the write setup state forms a loop
    assign done_o = (cnt_q == 4'h0);
endmodule // sram_dly_cnt
`default_nettype wire

// ### logic/sram_ctl.sv
/*
 Clocked controller for an asynchronous 128K x 8 static memory: turns
 single read and write requests into chip select, output enable and
 write strobe sequences. Assumes the memory pins are joined directly,
 the bench resolves the shared data bus from the enable.
*/
// Notes on behaviour
// - Write while select and write strobe low
// - Read: strobe high, select and enable low
// - Write spans both strobes' overlap
// - 131072 words, 17-bit address, 8-bit bus
// - Select low 10 ns before write end
// - Address stable 9 ns before write end
// - Address held through write end
// - Address valid by select assertion
// - Deselect before retention; wait after recovery
`include "sram_ctl_defines.svh"
`default_nettype none
module sram_ctl (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    input wire sram_ctl_pkg::mem_req_t req_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [`DATA_W-1:0] rd_data_o,
    input wire logic retain_i,
    output logic retain_ok_o,
    output sram_ctl_pkg::mem_ctrl_t mem_o,
    output logic [`DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic [`DATA_W-1:0] dq_i
);
    import sram_ctl_pkg::*;

    logic rst_meta_q;
    logic rst_n_q;
    logic [`DATA_W-1:0] dq_meta_q;
    logic [`DATA_W-1:0] dq_sync_q;
    logic ret_meta_q;
    logic ret_sync_q;

    // Reset release and pin inputs each pass two flops
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            dq_meta_q <= 8'h00;
            dq_sync_q <= 8'h00;
            ret_meta_q <= 1'b0;
            ret_sync_q <= 1'b0;
        end
        else
        begin
            dq_meta_q <= dq_i;
            dq_sync_q <= dq_meta_q;
            ret_meta_q <= retain_i;
            ret_sync_q <= ret_meta_q;
        end
    end

    ctl_state_t state_q, state_d;
    mem_ctrl_t mem_q, mem_d;
    logic [`DATA_W-1:0] dq_q, dq_d;
    logic dq_oe_q, dq_oe_d;
    logic ready_q, ready_d;
    logic rd_valid_q, rd_valid_d;
    logic [`DATA_W-1:0] rd_data_q, rd_data_d;
    logic retain_ok_q, retain_ok_d;
    logic cnt_load;
    logic [`CNT_W-1:0] cnt_val;
    logic cnt_done;

    // Delay timer; synchroniser adds two cycles on top of the count
    sram_dly_cnt u_dly (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .load_i(cnt_load),
        .value_i(cnt_val),
        .done_o(cnt_done)
    );

    // Sequencer: every timed phase lasts one cycle more than its loaded count
    always_comb
    begin
        state_d = state_q;
        mem_d = mem_q;
        dq_d = dq_q;
        dq_oe_d = dq_oe_q;
        ready_d = 1'b0;
        rd_valid_d = 1'b0;
        rd_data_d = rd_data_q;
        retain_ok_d = retain_ok_q;
        cnt_load = 1'b0;
        cnt_val = 4'h0;
        case (state_q)
            ST_IDLE:
            begin
                mem_d.chip_sel_n = 1'b1;
                mem_d.out_en_n = 1'b1;
                mem_d.write_n = 1'b1;
                dq_oe_d = 1'b0;
                ready_d = !ret_sync_q;
                if (ret_sync_q)
                begin
                    state_d = ST_RETAIN;
                    retain_ok_d = 1'b1;
                    ready_d = 1'b0;
                end
                else if (req_valid_i && ready_q)
                begin
                    ready_d = 1'b0;
                    // Address set with select, never after it
                    mem_d.word_address = req_i.addr;
                    mem_d.chip_sel_n = 1'b0;
                    cnt_load = 1'b1;
                    if (req_i.write)
                    begin
                        // Write strobe waits two cycles for the address
                        dq_d = req_i.wdata;
                        state_d = ST_WR_SETUP;
                        cnt_val = 4'(`BUS_RELEASE_CYC);
                    end
                    else
                    begin
                        mem_d.out_en_n = 1'b0;
                        state_d = ST_RD_WAIT;
                        cnt_val = 4'(`READ_WAIT_CYC + 2);
                    end
                end
            end
            ST_RD_WAIT:
                // Sample only after access time plus synchroniser lag
                if (cnt_done)
                begin
                    rd_data_d = dq_sync_q;
                    rd_valid_d = 1'b1;
                    mem_d.chip_sel_n = 1'b1; // address kept stable
                    mem_d.out_en_n = 1'b1;
                    state_d = ST_IDLE;
                end
            ST_WR_SETUP:
                if (cnt_done)
                begin
                    mem_d.write_n = 1'b0;
                    dq_oe_d = 1'b1;
                    cnt_load = 1'b1;
                    cnt_val = 4'(`WRITE_PULSE_CYC);
                    state_d = ST_WR_PULSE;
                end
            ST_WR_PULSE:
                if (cnt_done)
                begin
                    // Write strobe ends first; select and data held
                    mem_d.write_n = 1'b1;
                    state_d = ST_WR_END;
                end
            ST_WR_END:
            begin
                mem_d.chip_sel_n = 1'b1;
                dq_oe_d = 1'b0;
                state_d = ST_IDLE;
            end
            ST_RETAIN:
                // Stay deselected; recover one read cycle after release
                if (!ret_sync_q && retain_ok_q)
                begin
                    retain_ok_d = 1'b0;
                    cnt_load = 1'b1;
                    cnt_val = 4'(`RECOVERY_CYC);
                end
                else if (!ret_sync_q && cnt_done)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_IDLE;
            mem_q <= {17'h00000, 1'b1, 1'b1, 1'b1};
            dq_q <= 8'h00;
            dq_oe_q <= 1'b0;
            ready_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
            retain_ok_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            mem_q <= mem_d;
            dq_q <= dq_d;
            dq_oe_q <= dq_oe_d;
            ready_q <= ready_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            retain_ok_q <= retain_ok_d;
        end
    end

    assign mem_o = mem_q;
    assign dq_o = dq_q;
    assign dq_oe_o = dq_oe_q;
    assign req_ready_o = ready_q;
    assign rd_valid_o = rd_valid_q;
    assign rd_data_o = rd_data_q;
    assign retain_ok_o = retain_ok_q;

    // Write strobe only low while selected
    AST_WRITE_SELECTED: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) !mem_q.write_n |-> !mem_q.chip_sel_n)
        else $error("write strobe low while deselected");
    // Drive the bus only in the write pulse with output disabled, or in ST_WR_END
    AST_NO_CONTENTION: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) dq_oe_q |-> mem_q.out_en_n && !mem_q.write_n
        || dq_oe_q && mem_q.write_n && state_q == ST_WR_END)
        else $error("bus driven while output enabled");
    // Read enable covers at least the access time plus lag
    AST_READ_WAIT: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) $fell(mem_q.out_en_n)
        |-> !mem_q.out_en_n [*3])
        else $error("read window too short");
    // Write pulse lasts at least one full cycle, address stable
    AST_WRITE_PULSE: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) $fell(mem_q.write_n)
        |-> !mem_q.write_n ##1 $stable(mem_q.word_address))
        else $error("write pulse too short");
    // Address stays put while selected
    AST_ADDR_HOLD: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) !mem_q.chip_sel_n && !$past(mem_q.chip_sel_n)
        |-> $stable(mem_q.word_address))
        else $error("address moved during access");
    // Read result in the same cycle as deselect
    AST_READ_RESULT: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) state_q == ST_RD_WAIT && cnt_done
        |=> rd_valid_q && mem_q.chip_sel_n)
        else $error("read result missing");
    // Retention only while deselected
    AST_RETAIN_DESEL: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) state_q == ST_RETAIN |-> mem_q.chip_sel_n)
        else $error("selected during retention");
    // Select still low as the strobe ends, released one cycle later
    sequence s_select_release;
        !mem_q.chip_sel_n ##1 mem_q.chip_sel_n;
    endsequence
    // Write ends by strobe, then select releases next cycle
    AST_WRITE_END: assert property (@(posedge clk_i)
        disable iff (!rst_n_q) $rose(mem_q.write_n)
        |-> s_select_release)
        else $error("write end order wrong");
endmodule // sram_ctl
`default_nettype wire

// ### dv/sram_model.sv
/*
 Behavioural 128K x 8 static memory facing the controller.
 Assumes the bench resolves the shared bus and feeds it back here.
*/
`include "sram_ctl_defines.svh"
`default_nettype none
module sram_model (
    input wire sram_ctl_pkg::mem_ctrl_t pins_i,
    input wire logic [`DATA_W-1:0] bus_i,
    output logic [`DATA_W-1:0] data_o,
    output logic drive_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import sram_ctl_pkg::*;
    logic [`DATA_W-1:0] cells [0:`WORD_COUNT-1];
    logic sel;
    logic sel_late;
    // Read path drives only after the access time, drops at once
    assign sel = !pins_i.chip_sel_n && !pins_i.out_en_n && pins_i.write_n;
    assign #12 sel_late = sel;
    assign drive_o = sel && sel_late;
    // Old word stays on the output a short while after the address moves
    assign #4 data_o = cells[pins_i.word_address];
    // Level write, output enable ignored while both strobes are low
    always @*
    begin
        if (!pins_i.chip_sel_n && !pins_i.write_n)
            cells[pins_i.word_address] = bus_i;
    end
endmodule // sram_model
`default_nettype wire

// ### dv/sram_ctl_test.sv
/*
 Self-checking bench: corner and random accesses, retention.
 Assumes the design files and the memory model are compiled first.
*/
`include "sram_ctl_defines.svh"
`default_nettype none
module sram_ctl_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sram_ctl_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic req_valid_i = 1'b0;
    mem_req_t req_i = '0;
    logic retain_i = 1'b0;
    logic req_ready_o, rd_valid_o, retain_ok_o, dq_oe_o, m_drive;
    logic [7:0] rd_data_o, dq_o, m_data, bus;
    logic [7:0] prev_q = 8'h5A;
    logic [16:0] wa_q;
    mem_ctrl_t mem_o;
    logic [15:0] lfsr = 16'h004B;
    logic [7:0] shadow [int];
    int num_errors = 0;
    int n_compared = 0;
    always #25 clk_i = ~clk_i;
    // Floating bus shows a pattern that moves every cycle
    assign bus = dq_oe_o ? dq_o : (m_drive ? m_data : ~prev_q);
    sram_ctl u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .retain_i(retain_i),
        .retain_ok_o(retain_ok_o), .mem_o(mem_o), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .dq_i(bus));
    sram_model u_mem (.pins_i(mem_o), .bus_i(bus), .data_o(m_data),
        .drive_o(m_drive));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Next value of the stimulus shift register
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Expected read value: last byte written to that address
    function automatic logic [7:0] expected(input logic [16:0] addr);
        return shadow[addr];
    endfunction
    function automatic logic flag(input int k);
        return k == 0 ? req_ready_o : (k == 1 ? rd_valid_o : retain_ok_o);
    endfunction
    // Bounded wait, sampled one delay after each edge
    task automatic wait_flag(input int k);
        for (int n = 0; flag(k) !== 1'b1; n++)
        begin
            if (n == 100)
            begin
                num_errors++;
                $display("[ERR] wait %0d timed out", k);
                report_and_stop();
            end
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic access(input logic wr, input logic [16:0] a,
        input logic [7:0] d);
        wait_flag(0);
        req_valid_i = 1'b1;
        req_i = '{wr, a, d};
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
        if (wr)
            shadow[a] = d;
        else
        begin
            wait_flag(1);
            check("read data", rd_data_o, expected(a));
        end
    endtask
    // Strobe framing and address stability, sampled mid-cycle when settled
    always @(negedge clk_i)
    begin
        prev_q <= bus;
        wa_q <= mem_o.word_address;
        if (rstn_i && mem_o.write_n === 1'b0)
        begin
            check("select in write", mem_o.chip_sel_n, 1'b0);
            check("address in write", mem_o.word_address, wa_q);
            check("bus drive in write", dq_oe_o, 1'b1);
            check("memory off bus", m_drive, 1'b0);
        end
    end
    initial
    begin
        logic [16:0] a;
        repeat (2) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        check("idle bus drive", dq_oe_o, 1'b0);
        access(1'b1, 17'h00000, 8'hA5);
        access(1'b1, 17'h1FFFF, 8'h5A);
        access(1'b0, 17'h00000, 8'h00);
        access(1'b0, 17'h1FFFF, 8'h00);
        check("idle model drive", m_drive, 1'b0);
        $display("test corners done");
        for (int i = 0; i < 12; i++)
        begin
            lfsr = lfsr_next(lfsr);
            a = {lfsr[3], lfsr};
            access(1'b1, a, lfsr[7:0]);
            access(1'b1, a ^ 17'h00001, lfsr[15:8]);
            access(1'b0, a, 8'h00);
            access(1'b0, a ^ 17'h00001, 8'h00);
        end
        $display("test random done");
        retain_i = 1'b1;
        wait_flag(2);
        check("select in retention", mem_o.chip_sel_n, 1'b1);
        check("ready in retention", req_ready_o, 1'b0);
        retain_i = 1'b0;
        access(1'b0, 17'h1FFFF, 8'h00);
        check("ok after recovery", retain_ok_o, 1'b0);
        $display("test retention done");
        report_and_stop();
    end
endmodule // sram_ctl_test
`default_nettype wire
